// ==== design/irlc_params.svh ====
`ifndef IRLC_PARAMS_SVH
`define IRLC_PARAMS_SVH

`define IRLC_ADDR_W          12
`define IRLC_OVW_LOW_ADDR    12'h200
`define IRLC_OVW_HIGH_ADDR   12'h204
`define IRLC_LINE_PAGE       4'h4
`define IRLC_LINE_FIRST      6'h01
`define IRLC_LOW_LAST        20

`define IRLC_BIT_PENDING     31
`define IRLC_BIT_SOFT_RAISE  30
`define IRLC_BIT_SOFT_DROP   29
`define IRLC_BIT_WE_POLARITY 25
`define IRLC_BIT_ACTIVE_LOW  17

`define IRLC_LINE_PWM1       21
`define IRLC_LINE_PWM1_CAP   22
`define IRLC_LINE_PWM2       23
`define IRLC_LINE_PWM2_CAP   24
`define IRLC_LINE_PWM3       25
`define IRLC_LINE_PWM3_CAP   26
`define IRLC_LINE_EVENT      27
`define IRLC_LINE_SERIAL0    28
`define IRLC_LINE_SERIAL1    29
`define IRLC_LINE_CAN_GEN    36
`define IRLC_LINE_CAN_RX0    37
`define IRLC_LINE_CAN_RX1    38
`define IRLC_LINE_CAN_TX0    43
`define IRLC_LINE_CAN_TX1    44

`define IRLC_RST_SOFT        63'h0
`define IRLC_RST_ACTIVE_LOW  63'h0
`define IRLC_RST_WORD        32'h0

`endif

// ==== design/irlc_pkg.sv ====
`default_nettype none
package irlc_pkg;
  typedef logic [11:0] irlc_addr_t;
  typedef logic [31:0] irlc_word_t;
  typedef logic [63:1] irlc_vec_t;
  typedef logic [5:0]  irlc_idx_t;
endpackage
`default_nettype wire

// ==== design/irlc_top.sv ====
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "irlc_params.svh"

module irlc_top
  import irlc_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire irlc_pkg::irlc_addr_t addr,
  input  wire irlc_pkg::irlc_word_t wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output var  irlc_pkg::irlc_word_t rdata,
  input  wire logic [20:1]          low_line_req,
  input  wire logic [2:0]           pwm_irq,
  input  wire logic [2:0]           pwm_capture_irq,
  input  wire logic                 event_router_irq,
  input  wire logic [1:0]           serial_master_irq,
  input  wire logic [1:0]           error_warning_irq,
  input  wire logic [1:0]           data_overrun_irq,
  input  wire logic [1:0]           error_passive_irq,
  input  wire logic [1:0]           arbitration_lost_irq,
  input  wire logic [1:0]           bus_error_irq,
  input  wire logic                 acceptance_table_error_irq,
  input  wire logic [1:0]           frame_received_irq,
  input  wire logic [1:0]           identifier_ready_irq,
  input  wire logic [1:0]           frame_sent_irq,
  output var  irlc_pkg::irlc_vec_t  line_pending
);
  import irlc_pkg::*;

  logic       rst_meta_reg;
  logic       rst_sync_n;

  // reset released through two flops, asserted at once
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  // address decode
  irlc_idx_t line_idx;
  logic      line_hit;
  logic      wr_line;

  assign line_idx = addr[7:2];
  assign line_hit = (addr[11:8] == `IRLC_LINE_PAGE) && (line_idx >= `IRLC_LINE_FIRST)
                    && (addr[1:0] == 2'h0);
  assign wr_line  = wr && line_hit;

  // source assembly; vectors sized 63 so reserved lines stay 0
  irlc_vec_t src_vec;
  irlc_vec_t live_mask;

  always_comb begin
    src_vec   = '0;
    live_mask = '0;
    src_vec[`IRLC_LOW_LAST:1]       = low_line_req;
    live_mask[`IRLC_LOW_LAST:1]     = '1;
    src_vec[`IRLC_LINE_PWM1]        = pwm_irq[0];
    src_vec[`IRLC_LINE_PWM1_CAP]    = pwm_capture_irq[0];
    src_vec[`IRLC_LINE_PWM2]        = pwm_irq[1];
    src_vec[`IRLC_LINE_PWM2_CAP]    = pwm_capture_irq[1];
    src_vec[`IRLC_LINE_PWM3]        = pwm_irq[2];
    src_vec[`IRLC_LINE_PWM3_CAP]    = pwm_capture_irq[2];
    src_vec[`IRLC_LINE_EVENT]       = event_router_irq;
    src_vec[`IRLC_LINE_SERIAL0]     = serial_master_irq[0];
    src_vec[`IRLC_LINE_SERIAL1]     = serial_master_irq[1];
    src_vec[`IRLC_LINE_CAN_GEN]     = (|error_warning_irq) | (|data_overrun_irq)
                                    | (|error_passive_irq) | (|arbitration_lost_irq)
                                    | (|bus_error_irq) | acceptance_table_error_irq;
    src_vec[`IRLC_LINE_CAN_RX0]     = frame_received_irq[0] | identifier_ready_irq[0];
    src_vec[`IRLC_LINE_CAN_RX1]     = frame_received_irq[1] | identifier_ready_irq[1];
    src_vec[`IRLC_LINE_CAN_TX0]     = frame_sent_irq[0];
    src_vec[`IRLC_LINE_CAN_TX1]     = frame_sent_irq[1];
    live_mask[`IRLC_LINE_CAN_TX1:`IRLC_LINE_PWM1] = '0;
    live_mask[`IRLC_LINE_SERIAL1:`IRLC_LINE_PWM1] = '1;
    live_mask[`IRLC_LINE_CAN_RX1:`IRLC_LINE_CAN_GEN] = '1;
    live_mask[`IRLC_LINE_CAN_TX1:`IRLC_LINE_CAN_TX0] = '1;
  end

  // per-line state
  irlc_vec_t soft_reg;
  irlc_vec_t soft_next;
  irlc_vec_t act_low_reg;
  irlc_vec_t act_low_next;
  irlc_vec_t pending_reg;
  irlc_vec_t pending_next;

  always_comb begin
    soft_next    = soft_reg;
    act_low_next = act_low_reg;
    if (wr_line) begin
      // raise wins when both strobes are written together
      if (wdata[`IRLC_BIT_SOFT_RAISE]) begin
        soft_next[line_idx] = 1'b1;
      end else if (wdata[`IRLC_BIT_SOFT_DROP]) begin
        soft_next[line_idx] = 1'b0;
      end
      if (wdata[`IRLC_BIT_WE_POLARITY]) begin
        act_low_next[line_idx] = wdata[`IRLC_BIT_ACTIVE_LOW];
      end
    end
    // reserved lines masked after polarity so a tied input never fires
    pending_next = soft_reg | ((src_vec ^ act_low_reg) & live_mask);
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      soft_reg    <= `IRLC_RST_SOFT;
      act_low_reg <= `IRLC_RST_ACTIVE_LOW;
      pending_reg <= '0;
    end else begin
      soft_reg    <= soft_next;
      act_low_reg <= act_low_next;
      pending_reg <= pending_next;
    end
  end

  assign line_pending = pending_reg;

  // read path; write-only strobes and reserved bits read 0
  irlc_word_t line_word;
  irlc_word_t ovw_low;
  irlc_word_t ovw_high;
  irlc_word_t rdata_next;
  logic       rd_pend;

  assign rd_pend  = pending_reg[line_idx];
  assign ovw_low  = {pending_reg[31:1], 1'b0};
  assign ovw_high = pending_reg[63:32];

  always_comb begin
    line_word = '0;
    line_word[`IRLC_BIT_PENDING]    = rd_pend;
    line_word[`IRLC_BIT_ACTIVE_LOW] = act_low_reg[line_idx];
    rdata_next = '0;
    if (rd) begin
      if (line_hit) begin
        rdata_next = line_word;
      end else if (addr == `IRLC_OVW_LOW_ADDR) begin
        rdata_next = ovw_low;
      end else if (addr == `IRLC_OVW_HIGH_ADDR) begin
        rdata_next = ovw_high;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata <= `IRLC_RST_WORD;
    end else begin
      rdata <= rdata_next;
    end
  end

  a_soft_raise_set: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    wr_line && wdata[`IRLC_BIT_SOFT_RAISE] |=> soft_reg[$past(line_idx)] ##1 pending_reg[$past(line_idx, 2)])
    else $error("soft raise did not set request");

  a_soft_drop_clr: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    wr_line && wdata[`IRLC_BIT_SOFT_DROP] && !wdata[`IRLC_BIT_SOFT_RAISE]
    |=> !soft_reg[$past(line_idx)])
    else $error("soft drop did not clear request");

  a_soft_hold_idle: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    !wr_line |=> $stable(soft_reg) && $stable(act_low_reg))
    else $error("line state changed without a write");

  a_polarity_guard: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    wr_line && !wdata[`IRLC_BIT_WE_POLARITY] |=> $stable(act_low_reg))
    else $error("polarity changed without write enable");

  a_polarity_load: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    wr_line && wdata[`IRLC_BIT_WE_POLARITY]
    |=> act_low_reg[$past(line_idx)] == $past(wdata[`IRLC_BIT_ACTIVE_LOW]))
    else $error("polarity not loaded");

  a_read_word: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    rd && line_hit |=> rdata[`IRLC_BIT_PENDING] == $past(rd_pend)
    && rdata[`IRLC_BIT_SOFT_RAISE:`IRLC_BIT_SOFT_DROP] == 2'h0)
    else $error("request register read wrong");

  a_overview_low: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    rd && addr == `IRLC_OVW_LOW_ADDR |=> rdata == $past(ovw_low) && !rdata[0])
    else $error("overview read wrong");

  a_reserved_quiet: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    !soft_reg[40] && !soft_reg[63] |=> !pending_reg[40] && !pending_reg[63])
    else $error("reserved line pending without soft request");

  a_pwm_map: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pwm_capture_irq[2] && !act_low_reg[`IRLC_LINE_PWM3_CAP] |=> pending_reg[`IRLC_LINE_PWM3_CAP])
    else $error("modulator capture not on its line");

  a_event_map: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    event_router_irq && !act_low_reg[`IRLC_LINE_EVENT] |=> pending_reg[`IRLC_LINE_EVENT])
    else $error("event line missing");

  a_serial_map: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    serial_master_irq[1] && !act_low_reg[`IRLC_LINE_SERIAL1] |=> pending_reg[`IRLC_LINE_SERIAL1])
    else $error("serial master line missing");

  a_can_general: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    bus_error_irq[1] && !act_low_reg[`IRLC_LINE_CAN_GEN] |=> pending_reg[`IRLC_LINE_CAN_GEN])
    else $error("combined CAN line missing");

  a_can_receive: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    identifier_ready_irq[1] && !act_low_reg[`IRLC_LINE_CAN_RX1] |=> pending_reg[`IRLC_LINE_CAN_RX1])
    else $error("receive line missing");

  a_can_transmit: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    frame_sent_irq[0] && !act_low_reg[`IRLC_LINE_CAN_TX0] |=> pending_reg[`IRLC_LINE_CAN_TX0])
    else $error("transmit line missing");

  a_raise_wins: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    wr_line && wdata[`IRLC_BIT_SOFT_RAISE] && wdata[`IRLC_BIT_SOFT_DROP]
    |=> soft_reg[$past(line_idx)])
    else $error("raise lost against drop");

  a_soft_zero_write: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    wr_line && !wdata[`IRLC_BIT_SOFT_RAISE] && !wdata[`IRLC_BIT_SOFT_DROP] |=> $stable(soft_reg))
    else $error("zero strobes changed soft request");

  a_unmapped_write: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    wr && !line_hit |=> $stable(soft_reg) && $stable(act_low_reg))
    else $error("unmapped write changed line state");

  a_soft_one_line: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    $onehot0(soft_reg ^ $past(soft_reg)))
    else $error("soft request moved on several lines");

  a_polarity_one_line: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    $onehot0(act_low_reg ^ $past(act_low_reg)))
    else $error("polarity moved on several lines");

  a_read_polarity: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    rd && line_hit |=> rdata[`IRLC_BIT_ACTIVE_LOW] == $past(act_low_reg[line_idx]))
    else $error("polarity read back wrong");

  a_read_reserved_bits: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    rd && line_hit |=> rdata[28:18] == 11'h000 && rdata[16:0] == 17'h00000)
    else $error("reserved or write-enable bits read nonzero");

  a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    !rd |=> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");

  a_unmapped_read: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    rd && !line_hit && addr != `IRLC_OVW_LOW_ADDR && addr != `IRLC_OVW_HIGH_ADDR
    |=> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_overview_high: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    rd && addr == `IRLC_OVW_HIGH_ADDR |=> rdata == $past(pending_reg[63:32]))
    else $error("upper overview read wrong");

  a_soft_pending: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    soft_reg != '0 |=> (pending_reg & $past(soft_reg)) == $past(soft_reg))
    else $error("soft request not pending");

  a_reserved_ranges: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    soft_reg[35:30] == 6'h00 && soft_reg[42:39] == 4'h0 && soft_reg[63:45] == 19'h00000
    |=> pending_reg[35:30] == 6'h00 && pending_reg[42:39] == 4'h0
    && pending_reg[63:45] == 19'h00000)
    else $error("reserved range pending without soft request");

  a_pwm_general_1: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pwm_irq[0] && !act_low_reg[`IRLC_LINE_PWM1] |=> pending_reg[`IRLC_LINE_PWM1])
    else $error("modulator 1 general not on its line");

  a_pwm_general_2: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pwm_irq[1] && !act_low_reg[`IRLC_LINE_PWM2] |=> pending_reg[`IRLC_LINE_PWM2])
    else $error("modulator 2 general not on its line");

  a_pwm_general_3: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pwm_irq[2] && !act_low_reg[`IRLC_LINE_PWM3] |=> pending_reg[`IRLC_LINE_PWM3])
    else $error("modulator 3 general not on its line");

  a_pwm_capture_1: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pwm_capture_irq[0] && !act_low_reg[`IRLC_LINE_PWM1_CAP] |=> pending_reg[`IRLC_LINE_PWM1_CAP])
    else $error("modulator 1 capture not on its line");

  a_pwm_capture_2: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    pwm_capture_irq[1] && !act_low_reg[`IRLC_LINE_PWM2_CAP] |=> pending_reg[`IRLC_LINE_PWM2_CAP])
    else $error("modulator 2 capture not on its line");

  a_serial_master_0: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    serial_master_irq[0] && !act_low_reg[`IRLC_LINE_SERIAL0] |=> pending_reg[`IRLC_LINE_SERIAL0])
    else $error("serial master 0 line missing");

  a_can_warning: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    error_warning_irq[0] && !act_low_reg[`IRLC_LINE_CAN_GEN] |=> pending_reg[`IRLC_LINE_CAN_GEN])
    else $error("error warning not on combined line");

  a_can_overrun: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    data_overrun_irq[1] && !act_low_reg[`IRLC_LINE_CAN_GEN] |=> pending_reg[`IRLC_LINE_CAN_GEN])
    else $error("data overrun not on combined line");

  a_can_passive: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    error_passive_irq[0] && !act_low_reg[`IRLC_LINE_CAN_GEN] |=> pending_reg[`IRLC_LINE_CAN_GEN])
    else $error("error passive not on combined line");

  a_can_arbitration: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    arbitration_lost_irq[1] && !act_low_reg[`IRLC_LINE_CAN_GEN] |=> pending_reg[`IRLC_LINE_CAN_GEN])
    else $error("arbitration lost not on combined line");

  a_can_table: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    acceptance_table_error_irq && !act_low_reg[`IRLC_LINE_CAN_GEN]
    |=> pending_reg[`IRLC_LINE_CAN_GEN])
    else $error("table error not on combined line");

  a_can_rx_frame: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    frame_received_irq[0] && !act_low_reg[`IRLC_LINE_CAN_RX0] |=> pending_reg[`IRLC_LINE_CAN_RX0])
    else $error("frame received not on receive line");

  a_can_rx_ident: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    identifier_ready_irq[0] && !act_low_reg[`IRLC_LINE_CAN_RX0] |=> pending_reg[`IRLC_LINE_CAN_RX0])
    else $error("identifier ready not on receive line");

  a_can_transmit_1: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    frame_sent_irq[1] && !act_low_reg[`IRLC_LINE_CAN_TX1] |=> pending_reg[`IRLC_LINE_CAN_TX1])
    else $error("transmit line 1 missing");

  a_active_low_idle: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    !pwm_irq[0] && act_low_reg[`IRLC_LINE_PWM1] |=> pending_reg[`IRLC_LINE_PWM1])
    else $error("active low line not pending on low source");

  a_event_quiet: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    !event_router_irq && !act_low_reg[`IRLC_LINE_EVENT] && !soft_reg[`IRLC_LINE_EVENT]
    |=> !pending_reg[`IRLC_LINE_EVENT])
    else $error("event line pending without a cause");

  a_can_rx_quiet: assert property (@(posedge mclk) disable iff (!rst_sync_n)
    !frame_received_irq[0] && !identifier_ready_irq[0]
    && !act_low_reg[`IRLC_LINE_CAN_RX0] && !soft_reg[`IRLC_LINE_CAN_RX0]
    |=> !pending_reg[`IRLC_LINE_CAN_RX0])
    else $error("receive line pending without a cause");

endmodule

`default_nettype wire

// ==== verification/irlc_src_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// peripheral side: level requests launched on mclk
module irlc_src_model (
  input  wire logic        mclk,
  input  wire logic [45:0] src,
  output var  logic [45:0] drv
);
  // registered so every source moves just after an edge, like real ones
  always_ff @(posedge mclk) begin
    drv <= src;
  end
endmodule
`default_nettype wire

// ==== verification/irlc_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module irlc_top_tb;
  import irlc_pkg::*;
  logic        mclk;
  logic        rst_n;
  logic        wr;
  logic        rd;
  irlc_addr_t  addr;
  irlc_word_t  wdata;
  irlc_word_t  rdata;
  irlc_word_t  got;
  irlc_vec_t   line_pending;
  logic [45:0] src;
  logic [45:0] drv;
  int          num_errors;
  int          n_compared;
  int          cycles;

  irlc_src_model peer (.mclk(mclk), .src(src), .drv(drv));
  irlc_top dut (
    .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .low_line_req(drv[19:0]), .pwm_irq(drv[22:20]),
    .pwm_capture_irq(drv[25:23]), .event_router_irq(drv[26]),
    .serial_master_irq(drv[28:27]), .error_warning_irq(drv[30:29]),
    .data_overrun_irq(drv[32:31]), .error_passive_irq(drv[34:33]),
    .arbitration_lost_irq(drv[36:35]), .bus_error_irq(drv[38:37]),
    .acceptance_table_error_irq(drv[39]), .frame_received_irq(drv[41:40]),
    .identifier_ready_irq(drv[43:42]), .frame_sent_irq(drv[45:44]),
    .line_pending(line_pending)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic wrap_up;
    if (num_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // generous ceiling, the sequence needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic irlc_addr_t la(input int n);
    return 12'h400 + 12'(4 * n);
  endfunction

  task automatic wr32(input irlc_addr_t a, input irlc_word_t d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // idle edges first: pending lags a write by two edges
  task automatic rd32(input irlc_addr_t a, output irlc_word_t d);
    repeat (2) @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // hardware source bit k of the partner vector to its request line
  function automatic int tgt(input int k);
    if (k < 20) return k + 1;
    if (k < 23) return 21 + 2 * (k - 20);
    if (k < 26) return 22 + 2 * (k - 23);
    if (k < 29) return k + 1;
    if (k < 40) return 36;
    if (k < 42) return k - 3;
    if (k < 44) return k - 5;
    return k - 1;
  endfunction

  task automatic t_idle;
    #1 chk("pend_rst", {line_pending, 1'b0}, 64'h0);
    rd32(la(5), got);
    chk("reg_rst", 64'(got), 64'h0);
    rd32(12'h3fc, got);
    chk("unmapped", 64'(got), 64'h0);
    rd32(12'h400, got);
    chk("line0", 64'(got), 64'h0);
  endtask

  task automatic t_map;
    int t;
    logic [63:0] e;
    for (int k = 0; k < 46; k++) begin
      t = tgt(k);
      e = 64'h1 << t;
      @(posedge mclk);
      src <= 46'h1 << k;
      repeat (3) @(posedge mclk);
      #1 chk("line_map", {line_pending, 1'b0}, e);
      rd32(la(t), got);
      chk("line_reg", 64'(got), 64'h8000_0000);
      rd32(t < 32 ? 12'h200 : 12'h204, got);
      chk("overview", 64'(got), t < 32 ? {32'h0, e[31:0]} : {32'h0, e[63:32]});
    end
    @(posedge mclk);
    src <= '0;
  endtask

  task automatic t_soft;
    wr32(la(50), 32'h4000_0000);
    rd32(la(50), got);
    chk("soft_reg", 64'(got), 64'h8000_0000);
    chk("soft_line", {line_pending, 1'b0}, 64'h1 << 50);
    rd32(12'h204, got);
    chk("ovw_high", 64'(got), 64'h4_0000);
    wr32(la(50), 32'h0);
    rd32(la(50), got);
    chk("soft_hold", 64'(got), 64'h8000_0000);
    wr32(la(50), 32'h2000_0000);
    rd32(la(50), got);
    chk("soft_drop", 64'(got), 64'h0);
    wr32(la(50), 32'h6000_0000);
    rd32(la(50), got);
    chk("raise_wins", 64'(got), 64'h8000_0000);
    wr32(la(50), 32'h2000_0000);
    wr32(la(1), 32'h4000_0000);
    rd32(12'h200, got);
    chk("ovw_low", 64'(got), 64'h2);
    wr32(la(1), 32'h2000_0000);
  endtask

  task automatic t_pol;
    wr32(la(21), 32'h0002_0000);
    rd32(la(21), got);
    chk("pol_locked", 64'(got), 64'h0);
    wr32(la(21), 32'h0202_0000);
    rd32(la(21), got);
    chk("pol_low", 64'(got), 64'h8002_0000);
    @(posedge mclk);
    src <= 46'h1 << 20;
    rd32(la(21), got);
    chk("pol_src_hi", 64'(got), 64'h0002_0000);
    @(posedge mclk);
    src <= '0;
    wr32(la(21), 32'h0200_0000);
    rd32(la(21), got);
    chk("pol_high", 64'(got), 64'h0);
    wr32(la(60), 32'h0202_0000);
    rd32(la(60), got);
    chk("pol_resv", 64'(got), 64'h0002_0000);
  endtask

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    src = '0;
    num_errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_idle();
    t_map();
    t_soft();
    t_pol();
    wrap_up();
  end
endmodule
`default_nettype wire
